// [hw/otfr_pkg.sv]
// constants for the output terminal function router
package otfr_pkg;

  localparam int          OTFR_NUM_GEN     = 5;
  localparam int          OTFR_NUM_OUT     = 6;
  localparam int          OTFR_RELAY_IDX   = 5;
  localparam int          OTFR_ADDR_W      = 8;
  localparam int          OTFR_DATA_W      = 8;
  localparam int          OTFR_SRC_W       = 64;
  localparam int          OTFR_TRIP_W3     = 3;
  localparam int          OTFR_TRIP_W4     = 4;

  // register map, one byte register per address
  localparam logic [7:0]  OTFR_FSEL_BASE   = 8'h00;
  localparam logic [7:0]  OTFR_POL_BASE    = 8'h08;
  localparam logic [7:0]  OTFR_TRIP_MODE_A = 8'h10;
  localparam logic [7:0]  OTFR_OUT_STAT_A  = 8'h11;

  localparam logic [7:0]  OTFR_FSEL_RST    = 8'h00;
  localparam logic        OTFR_POL_GEN_RST = 1'b0;
  localparam logic        OTFR_POL_REL_RST = 1'b1;

  localparam logic [1:0]  OTFR_TRIP_OFF    = 2'h0;
  localparam logic [1:0]  OTFR_TRIP_3BIT   = 2'h1;
  localparam logic [1:0]  OTFR_TRIP_4BIT   = 2'h2;

  // function-select codes (binary value of the decimal code)
  localparam logic [5:0]  OTFR_FN_RUN      = 6'h00;
  localparam logic [5:0]  OTFR_FN_CSA      = 6'h01;
  localparam logic [5:0]  OTFR_FN_OSF      = 6'h02;
  localparam logic [5:0]  OTFR_FN_OLW      = 6'h03;
  localparam logic [5:0]  OTFR_FN_LDEV     = 6'h04;
  localparam logic [5:0]  OTFR_FN_TRIP     = 6'h05;
  localparam logic [5:0]  OTFR_FN_SFO      = 6'h06;
  localparam logic [5:0]  OTFR_FN_OTQ      = 6'h07;
  localparam logic [5:0]  OTFR_FN_MPL      = 6'h08;
  localparam logic [5:0]  OTFR_FN_UNDV     = 6'h09;
  localparam logic [5:0]  OTFR_FN_TLIM     = 6'h0A;
  localparam logic [5:0]  OTFR_FN_RTO      = 6'h0B;
  localparam logic [5:0]  OTFR_FN_PTO      = 6'h0C;
  localparam logic [5:0]  OTFR_FN_THW      = 6'h0D;
  localparam logic [5:0]  OTFR_FN_BRL      = 6'h13;
  localparam logic [5:0]  OTFR_FN_BERR     = 6'h14;
  localparam logic [5:0]  OTFR_FN_ZFD      = 6'h15;
  localparam logic [5:0]  OTFR_FN_SDEV     = 6'h16;
  localparam logic [5:0]  OTFR_FN_POSR     = 6'h17;
  localparam logic [5:0]  OTFR_FN_OSF_B    = 6'h18;
  localparam logic [5:0]  OTFR_FN_SFO_B    = 6'h19;
  localparam logic [5:0]  OTFR_FN_OLW_B    = 6'h1A;
  localparam logic [5:0]  OTFR_FN_DISC0    = 6'h1B;
  localparam logic [5:0]  OTFR_FN_FBST     = 6'h1F;
  localparam logic [5:0]  OTFR_FN_NETE     = 6'h20;
  localparam logic [5:0]  OTFR_FN_LOG0     = 6'h21;
  localparam logic [5:0]  OTFR_FN_CAPW     = 6'h27;
  localparam logic [5:0]  OTFR_FN_FANW     = 6'h28;
  localparam logic [5:0]  OTFR_FN_STCT     = 6'h29;
  localparam logic [5:0]  OTFR_FN_HSOH     = 6'h2A;
  localparam logic [5:0]  OTFR_FN_LLD      = 6'h2B;
  localparam logic [5:0]  OTFR_FN_ORDY     = 6'h32;
  localparam logic [5:0]  OTFR_FN_FWD      = 6'h33;
  localparam logic [5:0]  OTFR_FN_REV      = 6'h34;
  localparam logic [5:0]  OTFR_FN_FATAL    = 6'h35;
  localparam logic [5:0]  OTFR_FN_WCMP0    = 6'h36;

endpackage

// [hw/otfr_router.sv]
// output terminal function router: selects, inverts and registers six outputs
//
// What this block does
// (RL1) five general outputs, one relay, each selectable
// (RL2) general outputs open-collector, sixth drives relay
// (RL3) per-output polarity: 00 open, 01 inverted
// (RL4) reset polarity: general 00, relay 01
// (RL5) trip code takes outputs 1-3 or 1-4
// (RL6) relay open and closed paths always opposite
// (RL7) relay open path follows signal, inverted by 01
// (RL8) codes 00,01,02,06,24,25 running and arrivals
// (RL9) codes 03,26 overload, 04 deviation, 31 feedback
// (RL10) codes 05 trip, 53 fatal, 19/20 brake
// (RL11) code 08 power loss, 09 undervoltage
// (RL12) codes 07,10,22,21,23 torque, speed, position
// (RL13) codes 11,12 time over, 13 thermal
// (RL14) codes 27-29 disconnect, 54-56 window compare
// (RL15) codes 33-38 logic results one to six
// (RL16) codes 39,40,42 life/overheat, 32 network error
// (RL17) code 41 starting contact, 43 light load
// (RL18) code 50 ready, 51/52 forward, reverse
// (RL19) running also set during injection braking
// (RL20) unassigned codes give inactive signal
// (RL21) outputs registered, value xor polarity, reset inactive
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module otfr_router
  import otfr_pkg::*;
#(
  parameter int NUM_GEN = OTFR_NUM_GEN
)
(
  input  wire logic                   sys_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic [OTFR_ADDR_W-1:0] reg_addr_i,
  input  wire logic [OTFR_DATA_W-1:0] reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [OTFR_DATA_W-1:0] reg_rdata_o,
  input  wire logic                   running_i,
  input  wire logic                   dc_braking_i,
  input  wire logic                   constant_speed_arrival_i,
  input  wire logic                   over_set_freq_arrival_i,
  input  wire logic                   set_freq_only_arrival_i,
  input  wire logic                   over_set_freq_arrival_b_i,
  input  wire logic                   set_freq_only_arrival_b_i,
  input  wire logic                   overload_warning_i,
  input  wire logic                   overload_warning_b_i,
  input  wire logic                   loop_deviation_excess_i,
  input  wire logic                   trip_alarm_i,
  input  wire logic                   overtorque_i,
  input  wire logic                   momentary_power_loss_i,
  input  wire logic                   undervoltage_i,
  input  wire logic                   torque_limited_i,
  input  wire logic                   run_time_over_i,
  input  wire logic                   power_on_time_over_i,
  input  wire logic                   thermal_warning_i,
  input  wire logic                   brake_release_i,
  input  wire logic                   brake_error_i,
  input  wire logic                   zero_freq_detect_i,
  input  wire logic                   speed_deviation_excess_i,
  input  wire logic                   position_ready_i,
  input  wire logic                   voltage_input_disconnect_i,
  input  wire logic                   current_input_disconnect_i,
  input  wire logic                   aux_input_disconnect_i,
  input  wire logic                   feedback_loop_status_i,
  input  wire logic                   network_error_i,
  input  wire logic [5:0]             logic_result_i,
  input  wire logic                   capacitor_life_warning_i,
  input  wire logic                   fan_life_warning_i,
  input  wire logic                   starting_contact_i,
  input  wire logic                   heatsink_overheat_i,
  input  wire logic                   light_load_detect_i,
  input  wire logic                   operation_ready_i,
  input  wire logic                   forward_running_i,
  input  wire logic                   reverse_running_i,
  input  wire logic                   fatal_fault_i,
  input  wire logic                   window_cmp_voltage_in_i,
  input  wire logic                   window_cmp_current_in_i,
  input  wire logic                   window_cmp_aux_in_i,
  input  wire logic [3:0]             trip_code_i,
  output logic      [NUM_GEN-1:0]     general_out_o,
  output logic                        relay_open_path_o,
  output logic                        relay_closed_path_o
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration check

  // trip code placement and the status byte both assume five general outputs
  generate
    if (NUM_GEN != OTFR_NUM_GEN)
    begin : g_bad_num
      $error("otfr_router: general output count must be five");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // codes at or above 64 select nothing and read as inactive
  function automatic logic pick_src(input logic [7:0]            code,
                                    input logic [OTFR_SRC_W-1:0] src);
    logic res;
    res = 1'b0;
    if (code[7:6] == 2'h0)
    begin
      res = src[code[5:0]];
    end
    return res;
  endfunction

  // true when addr lies in [base, base + count)
  function automatic logic in_block(input logic [7:0] addr,
                                    input logic [7:0] base);
    return (addr >= base) && (addr < (base + 8'(OTFR_NUM_OUT)));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0]            fsel_r [OTFR_NUM_OUT];
  logic                  pol_r  [OTFR_NUM_OUT];
  logic [1:0]            trip_mode_r;
  logic [OTFR_SRC_W-1:0] src_vec;
  logic [NUM_GEN-1:0]    gen_nxt;
  logic                  relay_nxt;
  logic [OTFR_DATA_W-1:0] rdata_nxt;
  logic [2:0]            fidx;
  logic [2:0]            pidx;
  int                    trip_width;
  logic [NUM_GEN-1:0]    trip_vec;

  assign fidx = 3'(reg_addr_i - OTFR_FSEL_BASE);
  assign pidx = 3'(reg_addr_i - OTFR_POL_BASE);

  // code padded to the output count so no bit select runs past the code width
  assign trip_vec = NUM_GEN'(trip_code_i);

  ////////////////////////////////////////////////////////////////////////////
  // settings written by software

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < OTFR_NUM_OUT; i++)
      begin
        fsel_r[i] <= OTFR_FSEL_RST;
      end
    end
    else if (reg_wr_i && in_block(reg_addr_i, OTFR_FSEL_BASE))
    begin
      fsel_r[fidx] <= reg_wdata_i; // RL1
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < OTFR_NUM_OUT; i++)
      begin
        pol_r[i] <= (i == OTFR_RELAY_IDX) ? OTFR_POL_REL_RST : OTFR_POL_GEN_RST; // RL4
      end
    end
    else if (reg_wr_i && in_block(reg_addr_i, OTFR_POL_BASE))
    begin
      // only 00 and 01 are meaningful; bit 0 carries the choice
      pol_r[pidx] <= reg_wdata_i[0]; // RL3
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      trip_mode_r <= OTFR_TRIP_OFF;
    end
    else if (reg_wr_i && (reg_addr_i == OTFR_TRIP_MODE_A))
    begin
      trip_mode_r <= reg_wdata_i[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal signal table indexed by function code

  always_comb
  begin
    src_vec = '0; // RL20
    src_vec[OTFR_FN_RUN]    = running_i | dc_braking_i; // RL8 RL19
    src_vec[OTFR_FN_CSA]    = constant_speed_arrival_i; // RL8
    src_vec[OTFR_FN_OSF]    = over_set_freq_arrival_i; // RL8
    src_vec[OTFR_FN_SFO]    = set_freq_only_arrival_i; // RL8
    src_vec[OTFR_FN_OSF_B]  = over_set_freq_arrival_b_i; // RL8
    src_vec[OTFR_FN_SFO_B]  = set_freq_only_arrival_b_i; // RL8
    src_vec[OTFR_FN_OLW]    = overload_warning_i; // RL9
    src_vec[OTFR_FN_OLW_B]  = overload_warning_b_i; // RL9
    src_vec[OTFR_FN_LDEV]   = loop_deviation_excess_i; // RL9
    src_vec[OTFR_FN_FBST]   = feedback_loop_status_i; // RL9
    src_vec[OTFR_FN_TRIP]   = trip_alarm_i; // RL10
    src_vec[OTFR_FN_FATAL]  = fatal_fault_i; // RL10
    src_vec[OTFR_FN_BRL]    = brake_release_i; // RL10
    src_vec[OTFR_FN_BERR]   = brake_error_i; // RL10
    src_vec[OTFR_FN_MPL]    = momentary_power_loss_i; // RL11
    src_vec[OTFR_FN_UNDV]   = undervoltage_i; // RL11
    src_vec[OTFR_FN_OTQ]    = overtorque_i; // RL12
    src_vec[OTFR_FN_TLIM]   = torque_limited_i; // RL12
    src_vec[OTFR_FN_SDEV]   = speed_deviation_excess_i; // RL12
    src_vec[OTFR_FN_ZFD]    = zero_freq_detect_i; // RL12
    src_vec[OTFR_FN_POSR]   = position_ready_i; // RL12
    src_vec[OTFR_FN_RTO]    = run_time_over_i; // RL13
    src_vec[OTFR_FN_PTO]    = power_on_time_over_i; // RL13
    src_vec[OTFR_FN_THW]    = thermal_warning_i; // RL13
    src_vec[OTFR_FN_DISC0]      = voltage_input_disconnect_i; // RL14
    src_vec[OTFR_FN_DISC0 + 1]  = current_input_disconnect_i; // RL14
    src_vec[OTFR_FN_DISC0 + 2]  = aux_input_disconnect_i; // RL14
    src_vec[OTFR_FN_WCMP0]      = window_cmp_voltage_in_i; // RL14
    src_vec[OTFR_FN_WCMP0 + 1]  = window_cmp_current_in_i; // RL14
    src_vec[OTFR_FN_WCMP0 + 2]  = window_cmp_aux_in_i; // RL14
    src_vec[OTFR_FN_LOG0 +: 6]  = logic_result_i; // RL15
    src_vec[OTFR_FN_CAPW]   = capacitor_life_warning_i; // RL16
    src_vec[OTFR_FN_FANW]   = fan_life_warning_i; // RL16
    src_vec[OTFR_FN_HSOH]   = heatsink_overheat_i; // RL16
    src_vec[OTFR_FN_NETE]   = network_error_i; // RL16
    src_vec[OTFR_FN_STCT]   = starting_contact_i; // RL17
    src_vec[OTFR_FN_LLD]    = light_load_detect_i; // RL17
    src_vec[OTFR_FN_ORDY]   = operation_ready_i; // RL18
    src_vec[OTFR_FN_FWD]    = forward_running_i; // RL18
    src_vec[OTFR_FN_REV]    = reverse_running_i; // RL18
  end

  ////////////////////////////////////////////////////////////////////////////
  // output selection and polarity

  always_comb
  begin
    trip_width = 0;
    if (trip_mode_r == OTFR_TRIP_3BIT)
    begin
      trip_width = OTFR_TRIP_W3;
    end
    else if (trip_mode_r == OTFR_TRIP_4BIT)
    begin
      trip_width = OTFR_TRIP_W4;
    end
  end

  always_comb
  begin
    gen_nxt = '0;
    for (int i = 0; i < NUM_GEN; i++)
    begin
      if (i < trip_width)
      begin
        gen_nxt[i] = trip_vec[i] ^ pol_r[i]; // RL5 RL21
      end
      else
      begin
        gen_nxt[i] = pick_src(fsel_r[i], src_vec) ^ pol_r[i]; // RL1 RL3 RL21
      end
    end
  end

  // relay coil drive: high closes the open path
  assign relay_nxt = pick_src(fsel_r[OTFR_RELAY_IDX], src_vec)
                     ^ pol_r[OTFR_RELAY_IDX]; // RL7

  ////////////////////////////////////////////////////////////////////////////
  // output registers

  // a high bit turns the open-collector transistor on
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      general_out_o <= '0; // RL21
    end
    else
    begin
      general_out_o <= gen_nxt; // RL2 RL21
    end
  end

  // reset leaves the contacts as with the coil unpowered
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      relay_open_path_o   <= 1'b0; // RL7 RL21
      relay_closed_path_o <= 1'b1; // RL6
    end
    else
    begin
      relay_open_path_o   <= relay_nxt; // RL2 RL7
      relay_closed_path_o <= ~relay_nxt; // RL6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read-back

  // unmapped addresses read as zero so software can probe the map safely
  always_comb
  begin
    rdata_nxt = '0;
    if (in_block(reg_addr_i, OTFR_FSEL_BASE))
    begin
      rdata_nxt = fsel_r[fidx];
    end
    else if (in_block(reg_addr_i, OTFR_POL_BASE))
    begin
      rdata_nxt = {7'h00, pol_r[pidx]};
    end
    else if (reg_addr_i == OTFR_TRIP_MODE_A)
    begin
      rdata_nxt = {6'h00, trip_mode_r};
    end
    else if (reg_addr_i == OTFR_OUT_STAT_A)
    begin
      // live contact state lets software see what the terminals show
      rdata_nxt = {2'h0, relay_open_path_o, general_out_o};
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      reg_rdata_o <= '0;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= rdata_nxt;
    end
    else
    begin
      reg_rdata_o <= '0;
    end
  end

endmodule

// [tb/otfr_router_chk.sv]
// port assertions for the output router
`timescale 1ns/1ps
module otfr_router_chk
  import otfr_pkg::*;
#(
  parameter int NUM_GEN = OTFR_NUM_GEN
)
(
  input wire logic                   sys_clk_i,
  input wire logic                   rstn_i,
  input wire logic [OTFR_ADDR_W-1:0] reg_addr_i,
  input wire logic [OTFR_DATA_W-1:0] reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [OTFR_DATA_W-1:0] reg_rdata_o,
  input wire logic [NUM_GEN-1:0]     general_out_o,
  input wire logic                   relay_open_path_o,
  input wire logic                   relay_closed_path_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////////////////
  sequence wr_s(logic [7:0] lo, logic [7:0] hi);
    reg_wr_i && reg_addr_i >= lo && reg_addr_i <= hi;
  endsequence
  // a write straight followed by a read of the same place returns the kept bits
  property back_p(logic [7:0] lo, logic [7:0] hi, logic [7:0] m);
    logic [7:0] a;
    logic [7:0] d;
    (wr_s(lo, hi), a = reg_addr_i, d = reg_wdata_i) ##1 (reg_rd_i && reg_addr_i == a)
      |=> reg_rdata_o == (d & m);
  endproperty
  ////////////////////////////////////////////////////////////////////////
  relay_pair_a: assert property (disable iff (1'b0) relay_closed_path_o != relay_open_path_o)
    else $error("relay paths not opposite");
  rst_idle_a: assert property (disable iff (1'b0)
    !rstn_i |-> general_out_o == '0 && !relay_open_path_o)
    else $error("outputs active in reset");
  rd_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data without read");
  rd_unmap_a: assert property (reg_rd_i && (reg_addr_i > 8'h11 || reg_addr_i[2:1] == 2'b11)
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rd_stat_a: assert property (reg_rd_i && reg_addr_i == 8'h11
    |=> reg_rdata_o == {2'b00, $past(relay_open_path_o), $past(general_out_o)})
    else $error("status read wrong");
  fsel_back_a: assert property (back_p(8'h00, 8'h05, 8'hFF))
    else $error("select readback wrong");
  pol_back_a: assert property (back_p(8'h08, 8'h0D, 8'h01))
    else $error("polarity readback wrong");
  mode_back_a: assert property (back_p(8'h10, 8'h10, 8'h03))
    else $error("trip mode readback wrong");
endmodule

bind otfr_router otfr_router_chk #(.NUM_GEN(NUM_GEN)) u_chk (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .general_out_o(general_out_o),
  .relay_open_path_o(relay_open_path_o), .relay_closed_path_o(relay_closed_path_o));

// [tb/otfr_ctrl_model.sv]
// control equipment model reading the output contacts
`timescale 1ns/1ps
module otfr_ctrl_model
(
  input  wire logic       sys_clk_i,
  input  wire logic [4:0] gen_on_i,
  input  wire logic       open_path_i,
  input  wire logic       closed_path_i,
  output logic      [4:0] line_lvl_o,
  output logic            relay_fault_o
);
  // pulled-up sense lines read low while a transistor conducts
  assign line_lvl_o = ~gen_on_i;
  // equal paths would mean a welded changeover contact
  always_ff @(posedge sys_clk_i)
    relay_fault_o <= (open_path_i == closed_path_i);
endmodule

// [tb/otfr_router_tb.sv]
// testbench for the output router
`timescale 1ns/1ps
module otfr_router_tb import otfr_pkg::*;;
  logic        sys_clk_i = 1'b0;
  logic        rstn_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic [45:0] st = '0;
  logic [3:0]  trip = 4'h0;
  logic [4:0]  gen;
  logic        opn;
  logic        cls;
  logic [4:0]  lvl;
  logic        rfault;
  int          fails = 0;
  int          num_checks = 0;
  // code for each status bit, in port order
  logic [7:0]  fcode [46] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h06, 8'h18, 8'h19, 8'h03, 8'h1A,
    8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h13, 8'h14, 8'h15, 8'h16,
    8'h17, 8'h1B, 8'h1C, 8'h1D, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
    8'h28, 8'h29, 8'h2A, 8'h2B, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38};
  logic [7:0]  nocode [16] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h1E, 8'h2C, 8'h2D, 8'h2E,
    8'h2F, 8'h30, 8'h31, 8'h39, 8'h3F, 8'h40, 8'hFF};

  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  otfr_router uut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .running_i(st[0]), .dc_braking_i(st[1]),
    .constant_speed_arrival_i(st[2]), .over_set_freq_arrival_i(st[3]),
    .set_freq_only_arrival_i(st[4]), .over_set_freq_arrival_b_i(st[5]),
    .set_freq_only_arrival_b_i(st[6]), .overload_warning_i(st[7]),
    .overload_warning_b_i(st[8]), .loop_deviation_excess_i(st[9]), .trip_alarm_i(st[10]),
    .overtorque_i(st[11]), .momentary_power_loss_i(st[12]), .undervoltage_i(st[13]),
    .torque_limited_i(st[14]), .run_time_over_i(st[15]), .power_on_time_over_i(st[16]),
    .thermal_warning_i(st[17]), .brake_release_i(st[18]), .brake_error_i(st[19]),
    .zero_freq_detect_i(st[20]), .speed_deviation_excess_i(st[21]),
    .position_ready_i(st[22]), .voltage_input_disconnect_i(st[23]),
    .current_input_disconnect_i(st[24]), .aux_input_disconnect_i(st[25]),
    .feedback_loop_status_i(st[26]), .network_error_i(st[27]), .logic_result_i(st[33:28]),
    .capacitor_life_warning_i(st[34]), .fan_life_warning_i(st[35]),
    .starting_contact_i(st[36]), .heatsink_overheat_i(st[37]), .light_load_detect_i(st[38]),
    .operation_ready_i(st[39]), .forward_running_i(st[40]), .reverse_running_i(st[41]),
    .fatal_fault_i(st[42]), .window_cmp_voltage_in_i(st[43]),
    .window_cmp_current_in_i(st[44]), .window_cmp_aux_in_i(st[45]), .trip_code_i(trip),
    .general_out_o(gen), .relay_open_path_o(opn), .relay_closed_path_o(cls));

  otfr_ctrl_model u_ctrl (.sys_clk_i(sys_clk_i), .gen_on_i(gen), .open_path_i(opn),
    .closed_path_i(cls), .line_lvl_o(lvl), .relay_fault_o(rfault));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // a write just issued still shows its strobe: let an edge pass first
    if (reg_wr_i)
      @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    // data stand until this edge; its update lands after the sample
    @(posedge sys_clk_i);
    chk(reg_rdata_o, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
  endtask

  // relay is read through its open path inverted, so default polarity reads as the signal
  function automatic logic [7:0] pick(input int k);
    return (k == 5) ? {7'h00, ~opn} : {7'h00, gen[k]};
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    print_verdict();
  end

  initial
  begin
    int k;
    // a falling reset edge at time zero clears the flops before the first clock edge
    rstn_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    settle();
    chk({1'b0, cls, opn, gen}, 8'h20);
    for (int a = 0; a < 19; a++)
      rd(a[7:0], (a == 13) ? 8'h01 : (a == 17) ? 8'h20 : 8'h00);
    for (int i = 0; i < 46; i++)
    begin
      k = i % 6;
      st <= 46'h1 << i;
      wr(k[7:0], fcode[i]);
      rd(k[7:0], fcode[i]);
      settle();
      chk(pick(k), 8'h01);
      st <= ~(46'h1 << i);
      settle();
      chk(pick(k), (fcode[i] == 8'h00) ? 8'h01 : 8'h00);
    end
    st <= '1;
    for (int j = 0; j < 16; j++)
    begin
      wr(8'h00, nocode[j]);
      settle();
      chk(pick(0), 8'h00);
    end
    st <= '0;
    wr(8'h01, 8'h07);
    wr(8'h09, 8'h01);
    rd(8'h09, 8'h01);
    settle();
    chk(pick(1), 8'h01);
    wr(8'h09, 8'h02);
    rd(8'h09, 8'h00);
    settle();
    chk(pick(1), 8'h00);
    wr(8'h05, 8'h07);
    wr(8'h0D, 8'h00);
    settle();
    chk({6'h00, cls, opn}, 8'h02);
    st[11] <= 1'b1;
    settle();
    chk({6'h00, cls, opn}, 8'h01);
    chk({7'h00, rfault}, 8'h00);
    st[11] <= 1'b0;
    for (int o = 0; o < 5; o++)
      wr(o[7:0], 8'h07);
    wr(8'h08, 8'h01);
    trip <= 4'hA;
    wr(8'h10, 8'h01);
    rd(8'h10, 8'h01);
    settle();
    chk({3'h0, gen}, 8'h03);
    wr(8'h10, 8'h02);
    settle();
    chk({3'h0, gen}, 8'h0B);
    wr(8'h10, 8'h07);
    rd(8'h10, 8'h03);
    settle();
    chk({3'h0, gen}, 8'h01);
    chk({3'h0, lvl}, 8'h1E);
    wr(8'h07, 8'h55);
    wr(8'h11, 8'hFF);
    rd(8'h07, 8'h00);
    rd(8'h11, 8'h01);
    rstn_i <= 1'b0;
    @(posedge sys_clk_i);
    chk({1'b0, cls, opn, gen}, 8'h40);
    rstn_i <= 1'b1;
    rd(8'h0D, 8'h01);
    print_verdict();
  end
endmodule
